// ---- dv/fdp_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

module fdp_assertions (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         tx_active,
  input wire logic         inorder_withdrawn,
  input wire logic         rx_valid,
  input wire logic         data_bus_occupied_o,
  input wire logic         data_bus_occupied_oe,
  input wire logic         data_valid_strobe_o,
  input wire logic         data_valid_strobe_i,
  input wire logic         order_deferral_i,
  input wire logic [255:0] bus_data_o,
  input wire logic [31:0]  data_ecc_bits_o,
  input wire logic         data_ecc_bits_oe,
  input wire logic         data_parity_bits_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_occ_drive;
    data_bus_occupied_oe == data_bus_occupied_o && tx_active == data_bus_occupied_o;
  endproperty
  property p_first_strobe;
    $rose(data_bus_occupied_o) |-> data_valid_strobe_o;
  endproperty
  property p_strobe_owned;
    data_valid_strobe_o |-> data_bus_occupied_o;
  endproperty
  property p_idle_hold;
    data_bus_occupied_o && !data_valid_strobe_o |-> $stable(bus_data_o);
  endproperty
  property p_end_phase;
    $fell(data_bus_occupied_o) |-> $past(data_valid_strobe_o);
  endproperty
  property p_ecc_oe;
    data_ecc_bits_oe == data_bus_occupied_o;
  endproperty
  property p_par_oe;
    data_parity_bits_oe == data_bus_occupied_o;
  endproperty
  property p_order_deferral;
    order_deferral_i |-> ##[2:4] inorder_withdrawn;
  endproperty
  property p_rx_capture;
    data_valid_strobe_i && !data_bus_occupied_o |-> ##3 rx_valid;
  endproperty
  // Inversion leaves at most nine ones on a group's pins
  property p_inv_limit;
    data_valid_strobe_o |-> $countones({bus_data_o[15:0], data_ecc_bits_o[1:0]}) <= 9;
  endproperty

  a_occ_drive: assert property (p_occ_drive) else $error("occupied drive mismatch");
  a_first_strobe: assert property (p_first_strobe) else $error("phase without strobe");
  a_strobe_owned: assert property (p_strobe_owned) else $error("strobe outside phase");
  a_idle_hold: assert property (p_idle_hold) else $error("data moved in idle");
  a_end_phase: assert property (p_end_phase) else $error("phase end late");
  a_ecc_oe: assert property (p_ecc_oe) else $error("ecc not driven");
  a_par_oe: assert property (p_par_oe) else $error("parity not driven");
  a_order_deferral: assert property (p_order_deferral) else $error("deferral missed");
  a_rx_capture: assert property (p_rx_capture) else $error("capture missed");
  a_inv_limit: assert property (p_inv_limit) else $error("group not inverted");

  c_phase: cover property ($rose(data_bus_occupied_o));
  c_idle: cover property (data_bus_occupied_o && !data_valid_strobe_o);
  c_rx: cover property (rx_valid);
endmodule // fdp_assertions

bind fdp_data_phase fdp_assertions u_chk (
  .clk(clk), .reset_n(reset_n), .tx_active(tx_active),
  .inorder_withdrawn(inorder_withdrawn), .rx_valid(rx_valid),
  .data_bus_occupied_o(data_bus_occupied_o), .data_bus_occupied_oe(data_bus_occupied_oe),
  .data_valid_strobe_o(data_valid_strobe_o), .data_valid_strobe_i(data_valid_strobe_i),
  .order_deferral_i(order_deferral_i), .bus_data_o(bus_data_o),
  .data_ecc_bits_o(data_ecc_bits_o), .data_ecc_bits_oe(data_ecc_bits_oe),
  .data_parity_bits_oe(data_parity_bits_oe)
);

`default_nettype wire

// ---- dv/fdp_bus_agent.sv ----
`timescale 1ns/10ps
`default_nettype none

module fdp_bus_agent (
  input wire logic     clk,
  input wire logic     dut_occ,
  output logic         occ,
  output logic         strobe,
  output logic         order_deferral,
  output logic [255:0] data,
  output logic [15:0]  flags,
  output logic [15:0]  par,
  output logic [31:0]  ecc
);
  initial {occ, strobe, order_deferral, data, flags, par, ecc} = '0;

  function automatic logic [31:0] ecc_of(input logic [255:0] w);
    for (int i = 0; i < 16; i++) begin
      ecc_of[2*i]   = ^(w[16*i +: 16] & 16'h5555);
      ecc_of[2*i+1] = ^(w[16*i +: 16] & 16'hAAAA);
    end
  endfunction

  // Pins as {flags, ecc, parity, data}
  function automatic logic [319:0] enc(input logic [255:0] w);
    logic [31:0]  e;
    logic [15:0]  f;
    logic [15:0]  p;
    logic [255:0] d;
    e = ecc_of(w);
    for (int i = 0; i < 16; i++) begin
      p[i] = ^w[16*i +: 16];
      f[i] = $countones({w[16*i +: 16], e[2*i +: 2]}) > 9;
      d[16*i +: 16] = w[16*i +: 16] ^ {16{f[i]}};
      e[2*i +: 2] = e[2*i +: 2] ^ {2{f[i]}};
    end
    return {f, e, p, d};
  endfunction

  task automatic put(input logic [255:0] w, input logic bad = 1'b0);
    while (!occ && dut_occ) @(posedge clk) #1;
    // A bad word flips one parity and one ECC bit of group zero
    {flags, ecc, par, data} = enc(w) ^ {47'h0, bad, 15'h0, bad, 256'h0};
    occ = 1'b1;
    strobe = 1'b1;
    @(posedge clk) #1;
  endtask

  // Idle clock: lines scrambled since receivers must ignore them
  task automatic gap();
    strobe = 1'b0;
    {flags, ecc, par, data} = ~{flags, ecc, par, data};
    @(posedge clk) #1;
  endtask

  task automatic release_bus();
    occ = 1'b0;
    gap();
  endtask

  task automatic order_deferral_txn();
    order_deferral = 1'b1;
    @(posedge clk) #1;
    order_deferral = 1'b0;
  endtask
endmodule // fdp_bus_agent

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk, reset_n, tx_valid, tx_ready, tx_last, grant, txn_start, tx_active, withdrawn;
  logic rx_valid, rx_perr, rx_eerr, occ_o, occ_oe, str_o, str_oe, data_oe;
  logic a_occ, a_str, a_def;
  logic [255:0] tx_data, rx_data, data_o, a_data;
  logic [31:0]  rx_ecc, ecc_o, a_ecc;
  logic [15:0]  flags_o, par_o, a_flags, a_par;
  logic [255:0] tx_q[$];
  logic [257:0] rx_q[$];
  logic [257:0] rx_exp;
  logic [319:0] rx_want;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [255:0] EDGE_W = {8{16'h01FF, 16'h00FF}};

  fdp_data_phase dut (
    .clk(clk), .reset_n(reset_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .data_phase_grant(grant), .txn_start(txn_start),
    .tx_active(tx_active), .inorder_withdrawn(withdrawn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ecc(rx_ecc), .rx_parity_err(rx_perr), .rx_ecc_err(rx_eerr),
    .data_bus_occupied_i(occ_o | a_occ), .data_bus_occupied_o(occ_o),
    .data_bus_occupied_oe(occ_oe), .data_valid_strobe_i((str_oe & str_o) | a_str),
    .data_valid_strobe_o(str_o), .data_valid_strobe_oe(str_oe), .order_deferral_i(a_def),
    .bus_data_i(data_oe ? data_o : a_data), .bus_data_o(data_o), .bus_data_oe(data_oe),
    .bus_inversion_flags_i(data_oe ? flags_o : a_flags), .bus_inversion_flags_o(flags_o),
    .bus_inversion_flags_oe(), .data_ecc_bits_i(data_oe ? ecc_o : a_ecc),
    .data_ecc_bits_o(ecc_o), .data_ecc_bits_oe(), .data_parity_bits_i(data_oe ? par_o : a_par),
    .data_parity_bits_o(par_o), .data_parity_bits_oe()
  );

  fdp_bus_agent u_agent (
    .clk(clk), .dut_occ(occ_o), .occ(a_occ), .strobe(a_str), .order_deferral(a_def),
    .data(a_data), .flags(a_flags), .par(a_par), .ecc(a_ecc)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic check(input logic [319:0] got, input logic [319:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    if (str_o === 1'b1) begin
      if (tx_q.size() == 0)
        check(1, 0);
      else
        check({flags_o, ecc_o, par_o, data_o}, u_agent.enc(tx_q.pop_front()));
    end
    if (rx_valid === 1'b1) begin
      if (rx_q.size() == 0)
        check(1, 0);
      else begin
        rx_exp  = rx_q.pop_front();
        rx_want = {30'h0, rx_exp[257:256],
                   u_agent.ecc_of(rx_exp[255:0]) ^ {31'h0, rx_exp[256]}, rx_exp[255:0]};
        check({30'h0, rx_perr, rx_eerr, rx_ecc, rx_data}, rx_want);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  function automatic logic [255:0] rnd();
    for (int i = 0; i < 8; i++) rnd[32*i +: 32] = $urandom();
  endfunction

  task automatic push(input logic [255:0] w, input logic last);
    tx_valid = 1'b1;
    tx_data = w;
    tx_last = last;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    tx_q.push_back(w);
    #1;
  endtask

  task automatic send(input logic [255:0] w, input logic bad = 1'b0);
    rx_q.push_back({bad, bad, w});
    u_agent.put(w, bad);
  endtask

  task automatic drain();
    for (int i = 0; i < 60 && tx_q.size() + rx_q.size() != 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    check(tx_q.size() + rx_q.size(), 0);
  endtask

  initial begin
    {reset_n, tx_valid, tx_last, grant, txn_start, tx_data} = '0;
    void'($urandom(80));
    repeat (10) @(posedge clk);
    check({tx_ready, occ_o, rx_valid, withdrawn}, 4'h8);
    #1 reset_n = 1'b1;
    // Fill without grant until refused, then drain as one phase
    for (int i = 0; i < 8; i++) push(i == 0 ? '0 : i == 1 ? EDGE_W : rnd(), i == 7);
    tx_valid = 1'b0;
    check(tx_ready, 0);
    grant = 1'b1;
    drain();
    $display("test fill done");
    // Empty FIFO mid-phase gives idle clocks
    push(rnd(), 1'b0);
    tx_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    push('1, 1'b1);
    tx_valid = 1'b0;
    drain();
    $display("test idle done");
    // Far agent owns the bus; granted word must wait
    send(rnd());
    u_agent.gap();
    push(rnd(), 1'b1);
    tx_valid = 1'b0;
    u_agent.gap();
    u_agent.gap();
    check(occ_o, 0);
    send('1);
    // Corrupted protection bits must raise both error flags
    send(EDGE_W, 1'b1);
    u_agent.gap();
    send(rnd());
    u_agent.release_bus();
    drain();
    $display("test receive done");
    u_agent.order_deferral_txn();
    repeat (4) @(posedge clk);
    #1;
    check(withdrawn, 1);
    txn_start = 1'b1;
    @(posedge clk) #1;
    txn_start = 1'b0;
    @(posedge clk) #1;
    check(withdrawn, 0);
    // Deferral and a new transaction in one clock: the deferral wins
    u_agent.order_deferral_txn();
    @(posedge clk) #1;
    txn_start = 1'b1;
    @(posedge clk) #1;
    txn_start = 1'b0;
    @(posedge clk) #1;
    check(withdrawn, 1);
    $display("test deferral done");
    finish_test();
  end
endmodule // tb_top

`default_nettype wire

// ---- hdl/fdp_data_phase.sv ----
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Owner drives occupied; bus free once deasserted
// - Deferral withdraws the in-order completion promise
// - Data driver also drives eight ECC bits
// - Each ECC pair follows one inversion flag
// - Flagged pairs sent inverted; receiver undoes inversion
// - Data driver also drives four parity bits
// - Valid strobe marks each transfer; capture only then
// - Idle clocks drop the strobe; data ignored
// - Four data subphases per common clock
// - Flag active exactly when its group inverted
// - Invert 18-bit group when over half low
module fdp_data_phase
  import fdp_pkg::*;
#(
  parameter bit          ECC_EN     = 1'b1,
  parameter bit          PARITY_EN  = 1'b1,
  parameter int unsigned FIFO_DEPTH = FDP_FIFO_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // User transmit stream, one common clock of data per word
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire logic [FDP_WORD_W-1:0] tx_data,
  input  wire logic                  tx_last,
  input  wire logic                  data_phase_grant,
  input  wire logic                  txn_start,
  output logic                       tx_active,
  output logic                       inorder_withdrawn,
  // User receive side
  output logic                       rx_valid,
  output logic [FDP_WORD_W-1:0]      rx_data,
  output logic [FDP_ECCS_W-1:0]      rx_ecc,
  output logic                       rx_parity_err,
  output logic                       rx_ecc_err,
  // Bus pins, logical level, four subphases packed low first
  input  wire logic                  data_bus_occupied_i,
  output logic                       data_bus_occupied_o,
  output logic                       data_bus_occupied_oe,
  input  wire logic                  data_valid_strobe_i,
  output logic                       data_valid_strobe_o,
  output logic                       data_valid_strobe_oe,
  input  wire logic                  order_deferral_i,
  input  wire logic [FDP_WORD_W-1:0] bus_data_i,
  output logic [FDP_WORD_W-1:0]      bus_data_o,
  output logic                       bus_data_oe,
  input  wire logic [FDP_FLAG_W-1:0] bus_inversion_flags_i,
  output logic [FDP_FLAG_W-1:0]      bus_inversion_flags_o,
  output logic                       bus_inversion_flags_oe,
  input  wire logic [FDP_ECCS_W-1:0] data_ecc_bits_i,
  output logic [FDP_ECCS_W-1:0]      data_ecc_bits_o,
  output logic                       data_ecc_bits_oe,
  input  wire logic [FDP_FLAG_W-1:0] data_parity_bits_i,
  output logic [FDP_FLAG_W-1:0]      data_parity_bits_o,
  output logic                       data_parity_bits_oe
);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fdp_data_phase: FIFO_DEPTH below 2");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int unsigned SYNC_W = 3 + FDP_WORD_W + FDP_FLAG_W + FDP_ECCS_W + FDP_FLAG_W;

  logic [SYNC_W-1:0] pin_meta_reg;
  logic [SYNC_W-1:0] pin_sync_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {data_bus_occupied_i, data_valid_strobe_i, order_deferral_i,
                       bus_data_i, bus_inversion_flags_i, data_ecc_bits_i,
                       data_parity_bits_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic                  occ_s;
  logic                  strobe_s;
  logic                  order_deferral_s;
  logic [FDP_WORD_W-1:0] data_s;
  logic [FDP_FLAG_W-1:0] flags_s;
  logic [FDP_ECCS_W-1:0] ecc_s;
  logic [FDP_FLAG_W-1:0] par_s;

  assign {occ_s, strobe_s, order_deferral_s, data_s, flags_s, ecc_s, par_s} = pin_sync_reg;

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  localparam int unsigned FW = FDP_WORD_W + 1;

  fdp_stream_if #(.W(FW)) in_s ();
  fdp_stream_if #(.W(FW)) out_s ();

  assign in_s.valid = tx_valid;
  assign in_s.data  = {tx_last, tx_data};
  assign tx_ready   = in_s.ready;

  fdp_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .in_s    (in_s),
    .out_s   (out_s)
  );

  logic [FDP_WORD_W-1:0] head_data;
  logic                  head_last;

  assign head_data = out_s.data[FDP_WORD_W-1:0];
  assign head_last = out_s.data[FDP_WORD_W];

  // ****************************************************************
  // Data phase ownership
  // ****************************************************************
  fdp_state_t state_reg;
  logic       start;
  logic       pop;

  // Bus counts as free only when no other owner holds occupied
  assign start       = (state_reg == FDP_IDLE) & data_phase_grant & ~occ_s & out_s.valid;
  // An empty buffer mid-phase simply yields an idle clock
  assign out_s.ready = start | (state_reg == FDP_XFER);
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= FDP_IDLE;
    end else begin
      unique case (state_reg)
        FDP_IDLE: begin
          if (start && !head_last) begin
            state_reg <= FDP_XFER;
          end
        end
        FDP_XFER: begin
          if (pop && head_last) begin
            state_reg <= FDP_IDLE;
          end
        end
      endcase
    end
  end

  logic occ_reg;
  logic strobe_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      occ_reg    <= FDP_RST_FLAG;
      strobe_reg <= FDP_RST_FLAG;
    end else begin
      occ_reg    <= start | (state_reg == FDP_XFER);
      strobe_reg <= pop;
    end
  end

  // ****************************************************************
  // Subphase encoding
  // ****************************************************************
  logic [FDP_WORD_W-1:0] enc_data;
  logic [FDP_FLAG_W-1:0] enc_flags;
  logic [FDP_ECCS_W-1:0] enc_ecc;
  logic [FDP_FLAG_W-1:0] enc_par;
  logic [FDP_WORD_W-1:0] dec_data;
  logic [FDP_ECCS_W-1:0] dec_ecc;
  logic [FDP_FLAG_W-1:0] chk_ecc_err;
  logic [FDP_FLAG_W-1:0] chk_par_err;

  for (genvar s = 0; s < FDP_SUBPHASES; s++) begin : g_sub
    for (genvar g = 0; g < FDP_GROUPS; g++) begin : g_grp
      localparam int unsigned DI = s * FDP_LANE_W + g * FDP_GROUP_W;
      localparam int unsigned EI = s * FDP_ECC_W + g * FDP_PAIR_W;
      localparam int unsigned FI = s * FDP_GROUPS + g;

      logic [FDP_GROUP_W-1:0] raw;
      logic [FDP_PAIR_W-1:0]  pair;
      logic                   inv;
      logic [FDP_GROUP_W-1:0] rx_raw;
      logic [FDP_PAIR_W-1:0]  rx_pair;

      assign raw  = head_data[DI +: FDP_GROUP_W];
      assign pair = ECC_EN ? fdp_ecc_pair(raw) : 2'h0;
      // Asserted bits are driven low on the wire
      assign inv  = fdp_ones({pair, raw}) > FDP_INV_LIMIT;
      assign enc_flags[FI]                = inv;
      assign enc_data[DI +: FDP_GROUP_W]  = inv ? ~raw : raw;
      assign enc_ecc[EI +: FDP_PAIR_W]    = inv ? ~pair : pair;
      assign enc_par[FI]                  = PARITY_EN ? ^raw : 1'b0;

      // Receive side undoes the inversion of data and its pair
      assign rx_raw  = flags_s[FI] ? ~data_s[DI +: FDP_GROUP_W] : data_s[DI +: FDP_GROUP_W];
      assign rx_pair = flags_s[FI] ? ~ecc_s[EI +: FDP_PAIR_W] : ecc_s[EI +: FDP_PAIR_W];
      assign dec_data[DI +: FDP_GROUP_W] = rx_raw;
      assign dec_ecc[EI +: FDP_PAIR_W]   = rx_pair;
      assign chk_ecc_err[FI] = ECC_EN & (fdp_ecc_pair(rx_raw) != rx_pair);
      assign chk_par_err[FI] = PARITY_EN & ((^rx_raw) != par_s[FI]);
    end
  end

  logic [FDP_WORD_W-1:0] data_reg;
  logic [FDP_FLAG_W-1:0] flags_reg;
  logic [FDP_ECCS_W-1:0] ecc_reg;
  logic [FDP_FLAG_W-1:0] par_reg;

  // Lines hold their last value through idle clocks to save toggles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg  <= '0;
      flags_reg <= '0;
      ecc_reg   <= '0;
      par_reg   <= '0;
    end else if (pop) begin
      data_reg  <= enc_data;
      flags_reg <= enc_flags;
      ecc_reg   <= enc_ecc;
      par_reg   <= enc_par;
    end
  end

  assign data_bus_occupied_o    = occ_reg;
  assign data_bus_occupied_oe   = occ_reg;
  assign data_valid_strobe_o    = strobe_reg;
  assign data_valid_strobe_oe   = occ_reg;
  assign bus_data_o             = data_reg;
  assign bus_data_oe            = occ_reg;
  assign bus_inversion_flags_o  = flags_reg;
  assign bus_inversion_flags_oe = occ_reg;
  assign data_ecc_bits_o        = ecc_reg;
  assign data_ecc_bits_oe       = occ_reg & ECC_EN;
  assign data_parity_bits_o     = par_reg;
  assign data_parity_bits_oe    = occ_reg & PARITY_EN;
  assign tx_active              = occ_reg;

  // ****************************************************************
  // Order deferral
  // ****************************************************************
  logic withdrawn_reg;

  // A deferral seen in the same clock as a new transaction wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      withdrawn_reg <= FDP_RST_FLAG;
    end else if (order_deferral_s) begin
      withdrawn_reg <= 1'b1;
    end else if (txn_start) begin
      withdrawn_reg <= 1'b0;
    end
  end

  assign inorder_withdrawn = withdrawn_reg;

  // ****************************************************************
  // Receive capture
  // ****************************************************************
  // Own strobe returns through the synchroniser two clocks late
  logic [FDP_SYNC_STAGES-1:0] own_reg;
  logic                       capture;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      own_reg <= '0;
    end else begin
      own_reg <= {own_reg[FDP_SYNC_STAGES-2:0], occ_reg};
    end
  end

  assign capture = strobe_s & ~own_reg[FDP_SYNC_STAGES-1];

  logic                  rx_valid_reg;
  logic [FDP_WORD_W-1:0] rx_data_reg;
  logic [FDP_ECCS_W-1:0] rx_ecc_reg;
  logic                  rx_par_err_reg;
  logic                  rx_ecc_err_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_valid_reg <= FDP_RST_FLAG;
    end else begin
      rx_valid_reg <= capture;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_reg    <= '0;
      rx_ecc_reg     <= '0;
      rx_par_err_reg <= FDP_RST_FLAG;
      rx_ecc_err_reg <= FDP_RST_FLAG;
    end else if (capture) begin
      rx_data_reg    <= dec_data;
      rx_ecc_reg     <= dec_ecc;
      rx_par_err_reg <= |chk_par_err;
      rx_ecc_err_reg <= |chk_ecc_err;
    end
  end

  assign rx_valid      = rx_valid_reg;
  assign rx_data       = rx_data_reg;
  assign rx_ecc        = rx_ecc_reg;
  assign rx_parity_err = rx_par_err_reg;
  assign rx_ecc_err    = rx_ecc_err_reg;

endmodule // fdp_data_phase

`default_nettype wire

// ---- hdl/fdp_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module fdp_fifo
  import fdp_pkg::*;
#(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = FDP_FIFO_DEPTH
) (
  input wire logic    clk,
  input wire logic    reset_n,
  fdp_stream_if.snk   in_s,
  fdp_stream_if.src   out_s
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fdp_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  // Count is one bit wider than the pointers so full differs from empty
  assign in_s.ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (count_reg != '0);
  assign out_s.data  = mem[rd_ptr_reg];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // fdp_fifo

`default_nettype wire

// ---- hdl/fdp_pkg.sv ----
package fdp_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned FDP_SUBPHASES = 4;
  localparam int unsigned FDP_LANE_W    = 64;
  localparam int unsigned FDP_GROUPS    = 4;
  localparam int unsigned FDP_GROUP_W   = 16;
  localparam int unsigned FDP_PAIR_W    = 2;
  localparam int unsigned FDP_ECC_W     = FDP_GROUPS * FDP_PAIR_W;
  localparam int unsigned FDP_PAR_W     = FDP_GROUPS;
  localparam int unsigned FDP_WORD_W    = FDP_SUBPHASES * FDP_LANE_W;
  localparam int unsigned FDP_FLAG_W    = FDP_SUBPHASES * FDP_GROUPS;
  localparam int unsigned FDP_ECCS_W    = FDP_SUBPHASES * FDP_ECC_W;
  localparam int unsigned FDP_INV_W     = FDP_GROUP_W + FDP_PAIR_W;
  localparam logic [4:0]  FDP_INV_LIMIT = 5'h09;
  localparam int unsigned FDP_FIFO_DEPTH = 8;
  localparam int unsigned FDP_SYNC_STAGES = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic FDP_RST_FLAG = 1'b0;

  typedef enum logic [0:0] {
    FDP_IDLE,
    FDP_XFER
  } fdp_state_t;

  function automatic logic [4:0] fdp_ones(input logic [FDP_INV_W-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < FDP_INV_W; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // Pair check code: parity of even bits, then parity of odd bits
  function automatic logic [1:0] fdp_ecc_pair(input logic [FDP_GROUP_W-1:0] d);
    logic [1:0] e;
    e = 2'h0;
    for (int i = 0; i < FDP_GROUP_W; i += 2) begin
      e[0] = e[0] ^ d[i];
      e[1] = e[1] ^ d[i+1];
    end
    return e;
  endfunction

endpackage

// ---- hdl/fdp_stream_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface fdp_stream_if #(parameter int unsigned W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire
